// file: tpo_top.sv
`timescale 1ns/100ps
`include "tpo_map.svh"
// ---------------------------------------------------------------
// Overview of operation
// - Sixteen pattern bits, each enabled on its own by enable bits.
// - Four groups of four bits: 0-3, 4-7, 8-11, 12-15.
// - Groups update together or independently, each on its trigger.
// - Each group picks one of four timer channels as its trigger.
// - Non-overlap mode splits falling and rising edges in time.
// - Selected group trigger also raises a transfer request pulse.
// - Low next data at FFA5 shared; split: group1 FFA5, group0 FFA7.
// - High next data at FFA4 shared; split: group3 FFA4, group2 FFA6.
// - Direction registers: eight bits, write-only, reset zero.
// - Low port bits 7..0 drive pattern outputs 7..0.
// - High port bits 7..0 drive pattern outputs 15..8.
// - Port data bits enabled for pattern output ignore writes.
// - Low port data holds current levels of groups 0 and 1.
// - Mode register resets to F0, read and write.
// - Trigger select resets FF; both enable registers reset 00.
// - On its trigger a group copies next data into port data.
// - Unused next-data nibbles ignore writes and read as ones.
// ---------------------------------------------------------------

module tpo_top (
  // Clock, reset and clock enable
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  // Wishbone classic slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [`TPO_ADR_W-1:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [`TPO_DAT_W-1:0] DAT_I,
  output logic [`TPO_DAT_W-1:0] DAT_O,
  output logic ACK_O,
  // Timer compare-match events, one bit per channel
  input wire tpo_pkg::tpo_cmp_t CMPA_I,
  input wire tpo_pkg::tpo_cmp_t CMPB_I,
  // Transfer requests, one bit per group
  output tpo_pkg::tpo_cmp_t DMA_REQ_O,
  // Pattern pins
  input wire tpo_pkg::tpo_pat_t PAT_I,
  output tpo_pkg::tpo_pat_t PAT_O,
  output tpo_pkg::tpo_pat_t PAT_OE_N_O
);

  import tpo_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  tpo_byte_t mode;
  tpo_byte_t trig_sel;
  tpo_byte_t en_hi;
  tpo_byte_t en_lo;
  tpo_nib_s nd_hi;
  tpo_nib_s nd_lo;
  tpo_byte_t oe_n_lo;
  tpo_byte_t oe_n_hi;
  tpo_byte_t out_lo;
  tpo_byte_t out_hi;
  tpo_byte_t rd_q;
  logic ack;
  tpo_cmp_t dma_req;
  tpo_pat_t pin_meta;
  tpo_pat_t pin_sync;

  // ---------------------------------------------------------------
  // Combinational signals
  // ---------------------------------------------------------------
  tpo_idx_t idx;
  tpo_byte_t wbyte;
  tpo_byte_t rdata;
  logic wr;
  logic req;
  tpo_layout_e lay_lo;
  tpo_layout_e lay_hi;
  tpo_cmp_t hit_a;
  tpo_cmp_t hit_b;
  tpo_pat_t nd_all;
  tpo_pat_t en_all;
  tpo_pat_t cur_all;
  tpo_pat_t next_pat;
  tpo_byte_t next_out_lo;
  tpo_byte_t next_out_hi;

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign DAT_O = {24'h00_0000, rd_q};
  assign ACK_O = ack;
  assign DMA_REQ_O = dma_req;
  assign PAT_O = {out_hi, out_lo};
  assign PAT_OE_N_O = {oe_n_hi, oe_n_lo};

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pin_meta <= 16'h0000;
      pin_sync <= 16'h0000;
    end else if (CE_I) begin
      pin_meta <= PAT_I;
      pin_sync <= pin_meta;
    end
  end

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  // Writes land on the edge where the master sees ack, so a request
  // that is withdrawn early never changes a register.
  assign idx = ADR_I[`TPO_ADR_W-1:2];
  assign wbyte = DAT_I[7:0];
  assign req = CYC_I & STB_I;
  assign wr = req & ack & WE_I & SEL_I[0];

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ack <= 1'b0;
    end else if (CE_I) begin
      ack <= req & ~ack;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rd_q <= 8'h00;
    end else if (CE_I && req && !ack) begin
      rd_q <= rdata;
    end
  end

  // ---------------------------------------------------------------
  // Next-data layout
  // ---------------------------------------------------------------
  always_comb begin
    if (trig_sel[1:0] == trig_sel[3:2]) begin
      lay_lo = TPO_SHARED;
    end else begin
      lay_lo = TPO_SPLIT;
    end
    if (trig_sel[5:4] == trig_sel[7:6]) begin
      lay_hi = TPO_SHARED;
    end else begin
      lay_hi = TPO_SPLIT;
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  // Direction registers are write-only and read as zero, as does
  // any unmapped index.
  always_comb begin
    rdata = 8'h00;
    if (idx == `TPO_IDX_MODE) begin
      rdata = mode;
    end else if (idx == `TPO_IDX_TRIG) begin
      rdata = trig_sel;
    end else if (idx == `TPO_IDX_EN_HI) begin
      rdata = en_hi;
    end else if (idx == `TPO_IDX_EN_LO) begin
      rdata = en_lo;
    end else if (idx == `TPO_IDX_ND_HI) begin
      if (lay_hi == TPO_SHARED) begin
        rdata = nd_hi;
      end else begin
        rdata = {nd_hi.hi, `TPO_NIB_RSVD};
      end
    end else if (idx == `TPO_IDX_ND_G2) begin
      if (lay_hi == TPO_SHARED) begin
        rdata = `TPO_BYTE_ONES;
      end else begin
        rdata = {`TPO_NIB_RSVD, nd_hi.lo};
      end
    end else if (idx == `TPO_IDX_ND_LO) begin
      if (lay_lo == TPO_SHARED) begin
        rdata = nd_lo;
      end else begin
        rdata = {nd_lo.hi, `TPO_NIB_RSVD};
      end
    end else if (idx == `TPO_IDX_ND_G0) begin
      if (lay_lo == TPO_SHARED) begin
        rdata = `TPO_BYTE_ONES;
      end else begin
        rdata = {`TPO_NIB_RSVD, nd_lo.lo};
      end
    end else if (idx == `TPO_IDX_OUT_LO) begin
      // Output pins read the latch, input pins read the wire
      rdata = (out_lo & ~oe_n_lo) | (pin_sync[7:0] & oe_n_lo);
    end else if (idx == `TPO_IDX_OUT_HI) begin
      rdata = (out_hi & ~oe_n_hi) | (pin_sync[15:8] & oe_n_hi);
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mode <= `TPO_RST_MODE;
    end else if (CE_I && wr && idx == `TPO_IDX_MODE) begin
      mode <= {`TPO_MODE_RSVD, wbyte[3:0]};
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      trig_sel <= `TPO_RST_TRIG;
    end else if (CE_I && wr && idx == `TPO_IDX_TRIG) begin
      trig_sel <= wbyte;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      en_hi <= `TPO_RST_EN;
    end else if (CE_I && wr && idx == `TPO_IDX_EN_HI) begin
      en_hi <= wbyte;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      en_lo <= `TPO_RST_EN;
    end else if (CE_I && wr && idx == `TPO_IDX_EN_LO) begin
      en_lo <= wbyte;
    end
  end

  // ---------------------------------------------------------------
  // Direction registers
  // ---------------------------------------------------------------
  // Stored inverted so the enables leave straight from a flop.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      oe_n_lo <= ~`TPO_RST_DIR;
    end else if (CE_I && wr && idx == `TPO_IDX_DIR_LO) begin
      oe_n_lo <= ~wbyte;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      oe_n_hi <= ~`TPO_RST_DIR;
    end else if (CE_I && wr && idx == `TPO_IDX_DIR_HI) begin
      oe_n_hi <= ~wbyte;
    end
  end

  // ---------------------------------------------------------------
  // Next-data registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      nd_lo <= `TPO_RST_ND;
    end else if (CE_I && wr) begin
      if (idx == `TPO_IDX_ND_LO) begin
        nd_lo.hi <= wbyte[7:4];
        if (lay_lo == TPO_SHARED) begin
          nd_lo.lo <= wbyte[3:0];
        end
      end else if (idx == `TPO_IDX_ND_G0) begin
        if (lay_lo == TPO_SPLIT) begin
          nd_lo.lo <= wbyte[3:0];
        end
      end
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      nd_hi <= `TPO_RST_ND;
    end else if (CE_I && wr) begin
      if (idx == `TPO_IDX_ND_HI) begin
        nd_hi.hi <= wbyte[7:4];
        if (lay_hi == TPO_SHARED) begin
          nd_hi.lo <= wbyte[3:0];
        end
      end else if (idx == `TPO_IDX_ND_G2) begin
        if (lay_hi == TPO_SPLIT) begin
          nd_hi.lo <= wbyte[3:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Group trigger and pattern update
  // ---------------------------------------------------------------
  assign nd_all = {nd_hi, nd_lo};
  assign en_all = {en_hi, en_lo};
  assign cur_all = {out_hi, out_lo};

  // In non-overlap mode compare A only lets bits fall and compare B
  // only lets bits rise; the gap between the two is the margin.
  generate
    for (genvar g = 0; g < 4; g++) begin : g_grp
      logic [`TPO_SEL_W-1:0] sel;
      logic nov;
      logic [`TPO_GRP_W-1:0] nd;
      logic [`TPO_GRP_W-1:0] en;
      logic [`TPO_GRP_W-1:0] cur;
      logic [`TPO_GRP_W-1:0] upd;

      assign sel = trig_sel[2*g +: `TPO_SEL_W];
      assign nov = mode[`TPO_NOV_LSB + g];
      assign nd = nd_all[4*g +: `TPO_GRP_W];
      assign en = en_all[4*g +: `TPO_GRP_W];
      assign cur = cur_all[4*g +: `TPO_GRP_W];
      assign hit_a[g] = CMPA_I[sel];
      assign hit_b[g] = CMPB_I[sel];

      always_comb begin
        upd = cur;
        if (!nov) begin
          if (hit_a[g]) begin
            upd = nd;
          end
        end else begin
          if (hit_a[g]) begin
            upd = upd & nd;
          end
          if (hit_b[g]) begin
            upd = upd | nd;
          end
        end
      end

      // Only enabled bits follow the pattern; the rest hold
      assign next_pat[4*g +: `TPO_GRP_W] =
        (upd & en) | (cur & ~en);
    end
  endgenerate

  // ---------------------------------------------------------------
  // Port data registers
  // ---------------------------------------------------------------
  always_comb begin
    next_out_lo = next_pat[7:0];
    if (wr && idx == `TPO_IDX_OUT_LO) begin
      next_out_lo = (next_pat[7:0] & en_lo) | (wbyte & ~en_lo);
    end
    next_out_hi = next_pat[15:8];
    if (wr && idx == `TPO_IDX_OUT_HI) begin
      next_out_hi = (next_pat[15:8] & en_hi) | (wbyte & ~en_hi);
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      out_lo <= `TPO_RST_OUT;
    end else if (CE_I) begin
      out_lo <= next_out_lo;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      out_hi <= `TPO_RST_OUT;
    end else if (CE_I) begin
      out_hi <= next_out_hi;
    end
  end

  // ---------------------------------------------------------------
  // Transfer requests
  // ---------------------------------------------------------------
  // Raised whether or not the group has enabled bits, so a transfer
  // can preload next data before output is switched on.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      dma_req <= 4'h0;
    end else if (CE_I) begin
      dma_req <= hit_a;
    end
  end

endmodule // tpo_top

// file: tpo_map.svh
`ifndef TPO_MAP_SVH
`define TPO_MAP_SVH

// ---------------------------------------------------------------
// Bus geometry
// ---------------------------------------------------------------
`define TPO_ADR_W 18
`define TPO_DAT_W 32

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define TPO_IDX_MODE 16'hFFA0
`define TPO_IDX_TRIG 16'hFFA1
`define TPO_IDX_EN_HI 16'hFFA2
`define TPO_IDX_EN_LO 16'hFFA3
`define TPO_IDX_ND_HI 16'hFFA4
`define TPO_IDX_ND_LO 16'hFFA5
`define TPO_IDX_ND_G2 16'hFFA6
`define TPO_IDX_ND_G0 16'hFFA7
`define TPO_IDX_DIR_LO 16'hFFD1
`define TPO_IDX_OUT_LO 16'hFFD3
`define TPO_IDX_DIR_HI 16'hFFD4
`define TPO_IDX_OUT_HI 16'hFFD6

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define TPO_RST_MODE 8'hF0
`define TPO_RST_TRIG 8'hFF
`define TPO_RST_EN 8'h00
`define TPO_RST_ND 8'h00
`define TPO_RST_DIR 8'h00
`define TPO_RST_OUT 8'h00

// ---------------------------------------------------------------
// Field layout
// ---------------------------------------------------------------
`define TPO_MODE_RSVD 4'hF
`define TPO_NIB_RSVD 4'hF
`define TPO_BYTE_ONES 8'hFF
`define TPO_SEL_W 2
`define TPO_GRP_W 4
`define TPO_NOV_LSB 0

`endif

// file: tpo_pkg.sv
package tpo_pkg;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef logic [7:0] tpo_byte_t;
  typedef logic [3:0] tpo_cmp_t;
  typedef logic [15:0] tpo_pat_t;
  typedef logic [15:0] tpo_idx_t;

  typedef struct packed {
    logic [3:0] hi;
    logic [3:0] lo;
  } tpo_nib_s;

  typedef enum logic {
    TPO_SHARED,
    TPO_SPLIT
  } tpo_layout_e;

endpackage

// file: tpo_top_props.sv
`timescale 1ns/100ps
`include "tpo_map.svh"
module tpo_top_props (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  // Register bus
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [`TPO_DAT_W-1:0] DAT_O,
  input wire logic ACK_O,
  // Triggers and pins
  input wire tpo_pkg::tpo_cmp_t CMPA_I,
  input wire tpo_pkg::tpo_cmp_t CMPB_I,
  input wire tpo_pkg::tpo_cmp_t DMA_REQ_O,
  input wire tpo_pkg::tpo_pat_t PAT_O,
  input wire tpo_pkg::tpo_pat_t PAT_OE_N_O
);
  import tpo_pkg::*;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_dma_needs_cmp: assert property (
    DMA_REQ_O != 4'h0 |-> $past(CMPA_I) != 4'h0)
    else $error("transfer request without compare match");
  chk_dma_no_cmp: assert property (
    CE_I && CMPA_I == 4'h0 |=> DMA_REQ_O == 4'h0)
    else $error("transfer request after idle cycle");
  // A write to port data may also move the pins, so it is excluded
  chk_pat_hold: assert property (
    CE_I && CMPA_I == 4'h0 && CMPB_I == 4'h0 && !(ACK_O && WE_I)
    |=> $stable(PAT_O))
    else $error("pins moved without cause");
  chk_cmpb_rise_only: assert property (
    CE_I && CMPA_I == 4'h0 && !(ACK_O && WE_I)
    |=> ($past(PAT_O) & ~PAT_O) == 16'h0000)
    else $error("pin fell without compare match A");
  chk_oe_needs_wr: assert property (
    !(ACK_O && WE_I) |=> $stable(PAT_OE_N_O))
    else $error("direction changed without write");
  chk_ack_on_req: assert property (
    CYC_I && STB_I && !ACK_O && CE_I |=> ACK_O)
    else $error("no ack one cycle after request");
  chk_ack_single: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (ACK_O |-> $past(CYC_I && STB_I))
    else $error("ack without request");
  chk_dat_upper: assert property (ACK_O |-> DAT_O[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  cover property (DMA_REQ_O != 4'h0);
  cover property (ACK_O && WE_I);
  cover property (CMPB_I != 4'h0);
endmodule // tpo_top_props

bind tpo_top tpo_top_props tpo_top_props_inst (
  .CLK_I(CLK_I), .RST_I(RST_I), .CE_I(CE_I), .CYC_I(CYC_I),
  .STB_I(STB_I), .WE_I(WE_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
  .CMPA_I(CMPA_I), .CMPB_I(CMPB_I), .DMA_REQ_O(DMA_REQ_O),
  .PAT_O(PAT_O), .PAT_OE_N_O(PAT_OE_N_O));

// file: tpo_load.sv
`timescale 1ns/100ps
module tpo_load (
  // Pin side of the block
  input wire tpo_pkg::tpo_pat_t pat_i,
  input wire tpo_pkg::tpo_pat_t oe_n_i,
  // Level the far device drives on released pins
  input wire tpo_pkg::tpo_pat_t ext_i,
  output tpo_pkg::tpo_pat_t pin_o
);
  import tpo_pkg::*;
  // Released pins show the far level, never the block's stale latch
  assign pin_o = (pat_i & ~oe_n_i) | (ext_i & oe_n_i);
endmodule // tpo_load

// file: timed_pattern_output_tb.sv
`timescale 1ns/100ps
module timed_pattern_output_tb;
  import tpo_pkg::*;
  logic CLK_I = 1'b0;
  logic RST_I = 1'b1;
  logic CE_I = 1'b1;
  logic CYC_I = 1'b0;
  logic STB_I = 1'b0;
  logic WE_I = 1'b0;
  logic [17:0] ADR_I = 18'h0_0000;
  logic [3:0] SEL_I = 4'h0;
  logic [31:0] DAT_I = 32'h0000_0000;
  logic [31:0] DAT_O;
  logic ACK_O;
  tpo_cmp_t CMPA_I = 4'h0;
  tpo_cmp_t CMPB_I = 4'h0;
  tpo_cmp_t DMA_REQ_O;
  tpo_pat_t PAT_I, PAT_O, PAT_OE_N_O;
  tpo_pat_t ext = 16'h3C5A;
  tpo_byte_t rd;
  int n_fail = 0;
  int n_compared = 0;
  // {index, write, read}; pattern pins set to output here
  logic [31:0] rows [11] = '{32'hFFA0_00F0, 32'hFFA1_1B1B,
    32'hFFA3_FFFF, 32'hFFA2_F0F0, 32'hFFA5_A5AF, 32'hFFA7_3CFC,
    32'hFFA4_969F, 32'hFFA6_5AFA, 32'hFFD1_FF00, 32'hFFD4_FF00,
    32'h1234_5500};
  // {compare A, requests, pins}
  logic [23:0] trig [4] = '{24'h42_00A0, 24'h81_00AC, 24'h24_00AC,
    24'h18_90AC};
  // {index, reset read}
  logic [23:0] rst [8] = '{24'hFFA0_F0, 24'hFFA1_FF, 24'hFFA2_00,
    24'hFFA3_00, 24'hFFA4_00, 24'hFFA5_00, 24'hFFD3_5A, 24'hFFD6_3C};

  tpo_top tpo_top_inst (.CLK_I(CLK_I), .RST_I(RST_I), .CE_I(CE_I),
    .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
    .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .CMPA_I(CMPA_I), .CMPB_I(CMPB_I), .DMA_REQ_O(DMA_REQ_O),
    .PAT_I(PAT_I), .PAT_O(PAT_O), .PAT_OE_N_O(PAT_OE_N_O));
  tpo_load tpo_load_inst (.pat_i(PAT_O), .oe_n_i(PAT_OE_N_O),
    .ext_i(ext), .pin_o(PAT_I));

  always #5 CLK_I = ~CLK_I;

  task automatic complete_run;
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic bad(input string m);
    n_fail++;
    $display("[ERR] %0t %s", $time, m);
  endtask

  task automatic chk_rd(input tpo_byte_t g, input tpo_byte_t e);
    n_compared++;
    if (g !== e) bad("read data mismatch");
  endtask

  task automatic chk_pin(input tpo_pat_t g, input tpo_pat_t e);
    n_compared++;
    if (g !== e) bad("pin or request mismatch");
  endtask

  // Classic cycle; held until ack is sampled, then one idle cycle
  task automatic bus(input tpo_idx_t a, input logic w, input tpo_byte_t d);
    int n;
    n = 0;
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= w;
    ADR_I <= {a, 2'b00};
    DAT_I <= {24'h00_0000, d};
    SEL_I <= 4'h1;
    do begin
      @(posedge CLK_I);
      n++;
    end while (ACK_O !== 1'b1 && n < 50);
    if (ACK_O !== 1'b1) begin
      bad("no ack");
      complete_run;
    end
    rd = DAT_O[7:0];
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    WE_I <= 1'b0;
    @(posedge CLK_I);
  endtask

  // Outputs are read in the cycle after the pulse
  task automatic pulse(input tpo_cmp_t a, input tpo_cmp_t b,
                       input tpo_cmp_t q, input tpo_pat_t p);
    CMPA_I <= a;
    CMPB_I <= b;
    @(posedge CLK_I);
    CMPA_I <= 4'h0;
    CMPB_I <= 4'h0;
    @(posedge CLK_I);
    chk_pin({12'h000, DMA_REQ_O}, {12'h000, q});
    chk_pin(PAT_O, p);
  endtask

  initial begin
    repeat (20000) @(posedge CLK_I);
    bad("timeout");
    complete_run;
  end

  initial begin
    repeat (10) @(posedge CLK_I);
    RST_I <= 1'b0;
    @(posedge CLK_I);
    foreach (rows[i]) begin
      bus(rows[i][31:16], 1'b1, rows[i][15:8]);
      bus(rows[i][31:16], 1'b0, 8'h00);
      chk_rd(rd, rows[i][7:0]);
    end
    chk_pin(PAT_OE_N_O, 16'h0000);
    foreach (trig[i]) begin
      pulse(trig[i][23:20], 4'h0, trig[i][19:16], trig[i][15:0]);
    end
    bus(16'hFFD3, 1'b0, 8'h00);
    chk_rd(rd, 8'hAC);
    bus(16'hFFD3, 1'b1, 8'h00);
    bus(16'hFFD3, 1'b0, 8'h00);
    chk_rd(rd, 8'hAC);
    bus(16'hFFD6, 1'b1, 8'h0F);
    bus(16'hFFD6, 1'b0, 8'h00);
    chk_rd(rd, 8'h9F);
    bus(16'hFFA0, 1'b1, 8'h01);
    bus(16'hFFA7, 1'b1, 8'h03);
    pulse(4'h8, 4'h0, 4'h1, 16'h9FA0);
    pulse(4'h0, 4'h8, 4'h0, 16'h9FA3);
    bus(16'hFFA0, 1'b1, 8'h00);
    bus(16'hFFA1, 1'b1, 8'h00);
    bus(16'hFFA5, 1'b1, 8'h5A);
    bus(16'hFFA5, 1'b0, 8'h00);
    chk_rd(rd, 8'h5A);
    bus(16'hFFA7, 1'b0, 8'h00);
    chk_rd(rd, 8'hFF);
    pulse(4'h1, 4'h0, 4'hF, 16'h9F5A);
    // A trigger seen while the enable is low must leave no request
    CE_I <= 1'b0;
    CMPA_I <= 4'hF;
    @(posedge CLK_I);
    CE_I <= 1'b1;
    CMPA_I <= 4'h0;
    @(posedge CLK_I);
    chk_pin({12'h000, DMA_REQ_O}, 16'h0000);
    RST_I <= 1'b1;
    @(posedge CLK_I);
    RST_I <= 1'b0;
    @(posedge CLK_I);
    chk_pin(PAT_O, 16'h0000);
    chk_pin(PAT_OE_N_O, 16'hFFFF);
    foreach (rst[i]) begin
      bus(rst[i][23:8], 1'b0, 8'h00);
      chk_rd(rd, rst[i][7:0]);
    end
    complete_run;
  end
endmodule // timed_pattern_output_tb
